// *** hw/tmc_core.sv ***
// dual timer with shared mode register, gating and clock source choice
// Notes on behaviour
// R1 - gate bit clear: timer 1 runs whenever its run bit is set, except in mode 3
// R2 - gate bit set: timer 1 also needs its interrupt pin at the chosen level
// R3 - count select clear: timer 1 steps on the chosen internal timebase
// R4 - count select set: timer 1 steps once per falling edge of its count pin
// R5 - timer 1 modes: 13-bit, 16-bit, 8-bit auto-reload, stopped
// R6 - timer 0 gating works exactly as timer 1 with its own pin and polarity
// R7 - timer 0 steps on its chosen timebase or on falling edges of its pin
// R8 - timer 0 modes: 13-bit, 16-bit, 8-bit auto-reload, two 8-bit timers
// R9 - register: timer 1 fields upper nibble, timer 0 lower; gate, select, mode
// R10 - sources: clock, /4, /12, /48, external oscillator /8, count pin
// R11 - auto-reload mode reloads the low byte from the high byte on overflow
// R12 - external inputs synchronised, falling edges found from registered samples
`include "tmc_params.svh"
`default_nettype none
module tmc_core #(
    parameter int SYNC_STAGES = 2
) (
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    input  wire tmc_pkg::tmc_sfr_req_t sfr_req,
    output logic [7:0]                sfr_rdata,
    output logic [7:0]                timer_mode_reg,
    input  wire tmc_pkg::tmc_tmr_ctl_t timer0_ctl,
    input  wire tmc_pkg::tmc_tmr_ctl_t timer1_ctl,
    input  wire logic [1:0]           prescale_select,
    input  wire tmc_pkg::tmc_load_t    timer0_load,
    input  wire tmc_pkg::tmc_load_t    timer1_load,
    input  wire logic                 ext_irq0_pin,
    input  wire logic                 ext_irq1_pin,
    input  wire logic                 timer0_count_input,
    input  wire logic                 timer1_count_input,
    input  wire logic                 ext_osc_in,
    output logic [15:0]               timer0_count,
    output logic [15:0]               timer1_count,
    output logic                      timer0_overflow,
    output logic                      timer1_overflow
);
    logic [`TMC_IN_COUNT-1:0] in_level;
    logic [`TMC_IN_COUNT-1:0] in_fall;
    logic                     presc_tick;

    if (SYNC_STAGES < 2) $error("tmc_core: SYNC_STAGES must be at least 2");

    tmc_timebase #(
        .SYNC_STAGES (SYNC_STAGES),
        .N_IN        (`TMC_IN_COUNT)
    ) u_timebase (
        .clk_sys         (clk_sys),
        .rst_n           (rst_n),
        .async_in        ({ext_osc_in, ext_irq1_pin, ext_irq0_pin, timer1_count_input, timer0_count_input}),
        .prescale_select (prescale_select),
        .in_level        (in_level),
        .in_fall         (in_fall),
        .presc_tick      (presc_tick)
    );

    // one step of a timer in a given mode; overflow comes out beside the value
    function automatic tmc_pkg::tmc_step_t step(input tmc_pkg::tmc_mode_t m, input logic [7:0] hi,
                                               input logic [7:0] lo);
        tmc_pkg::tmc_step_t s;
        s = '{ovf: 1'b0, hi: hi, lo: lo};
        unique case (m)
            tmc_pkg::TMC_MODE_13BIT:
            begin
                // low five bits act as a prescaler below the high byte
                s.lo[4:0] = lo[4:0] + 5'd1;
                if (lo[4:0] == `TMC_M13_LOW_TOP)
                begin
                    s.hi  = hi + 8'd1;
                    s.ovf = (hi == `TMC_BYTE_TOP);
                end
            end
            tmc_pkg::TMC_MODE_16BIT:
                {s.ovf, s.hi, s.lo} = {1'b0, hi, lo} + 17'd1;
            tmc_pkg::TMC_MODE_8RELOAD:
            begin
                if (lo == `TMC_BYTE_TOP)
                begin
                    s.lo  = hi; // reload from the high byte
                    s.ovf = 1'b1;
                end
                else
                    s.lo = lo + 8'd1;
            end
            tmc_pkg::TMC_MODE_ALT:
            begin
                s.lo  = lo + 8'd1;
                s.ovf = (lo == `TMC_BYTE_TOP);
            end
        endcase
        return s;
    endfunction

    // mode register decode, fixed field layout [R9]
    wire timer0_gate_ctl = timer_mode_reg[`TMC_T0_GATE_BIT];
    wire timer1_gate_ctl = timer_mode_reg[`TMC_T1_GATE_BIT];
    wire csel0 = timer_mode_reg[`TMC_T0_CSEL_BIT];
    wire csel1 = timer_mode_reg[`TMC_T1_CSEL_BIT];
    wire tmc_pkg::tmc_mode_t mode0 = tmc_pkg::tmc_mode_t'(timer_mode_reg[`TMC_T0_MODE_LSB +: 2]); // [R8]
    wire tmc_pkg::tmc_mode_t mode1 = tmc_pkg::tmc_mode_t'(timer_mode_reg[`TMC_T1_MODE_LSB +: 2]); // [R5]
    wire mode_hit = (sfr_req.addr == `TMC_MODE_ADDR);

    // gate pins compare against the chosen active level [R2] [R6]
    wire irq0_active = (in_level[`TMC_IN_IRQ0] == timer0_ctl.irq_polarity);
    wire irq1_active = (in_level[`TMC_IN_IRQ1] == timer1_ctl.irq_polarity);

    // timebase: full rate when clk_select set, else the shared prescaler [R3] [R7] [R10]
    wire base0 = timer0_ctl.clk_select | presc_tick;
    wire base1 = timer1_ctl.clk_select | presc_tick;
    wire src0  = csel0 ? in_fall[`TMC_IN_T0] : base0; // [R7]
    wire src1  = csel1 ? in_fall[`TMC_IN_T1] : base1; // [R3] [R4]

    // run enables; mode 3 parks timer 1 but lets timer 0 split [R1] [R2] [R5] [R6]
    wire split0 = (mode0 == tmc_pkg::TMC_MODE_ALT);
    wire run0   = timer0_ctl.run & (~timer0_gate_ctl | irq0_active);
    wire run1   = timer1_ctl.run & (~timer1_gate_ctl | irq1_active) & (mode1 != tmc_pkg::TMC_MODE_ALT);
    wire en0    = run0 & src0;
    wire en1    = run1 & src1;
    // split mode: upper byte of timer 0 borrows timer 1's run bit, internal base only
    wire en0h   = split0 & timer1_ctl.run & base0; // [R8]

    wire tmc_pkg::tmc_step_t st0 = step(mode0, timer0_count[15:8], timer0_count[7:0]);
    wire tmc_pkg::tmc_step_t st1 = step(mode1, timer1_count[15:8], timer1_count[7:0]);
    wire [8:0] th0_inc = {1'b0, timer0_count[15:8]} + 9'd1;

    // next counter values; a software load beats a step in the same cycle
    wire [7:0] next_tl0 = timer0_load.lo_we ? timer0_load.data : (en0 ? st0.lo : timer0_count[7:0]);
    wire [7:0] next_th0 = timer0_load.hi_we ? timer0_load.data
                        : split0 ? (en0h ? th0_inc[7:0] : timer0_count[15:8])
                        : (en0 ? st0.hi : timer0_count[15:8]);
    wire [7:0] next_tl1 = timer1_load.lo_we ? timer1_load.data : (en1 ? st1.lo : timer1_count[7:0]); // [R11]
    wire [7:0] next_th1 = timer1_load.hi_we ? timer1_load.data : (en1 ? st1.hi : timer1_count[15:8]);
    wire next_ovf0 = en0 & st0.ovf;
    wire next_ovf1 = (en1 & st1.ovf) | (en0h & th0_inc[8]); // [R8]
    wire [7:0] next_rdata = (sfr_req.rd && mode_hit) ? timer_mode_reg : 8'h00;

    // mode register, written whole at its own address [R9]
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            timer_mode_reg <= `TMC_MODE_RESET;
        else if (sfr_req.wr && mode_hit)
            timer_mode_reg <= sfr_req.wdata;
    end

    // read data registered; unmapped reads return zero
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            sfr_rdata <= 8'h00;
        else
            sfr_rdata <= next_rdata;
    end

    // counters and one-cycle overflow pulses
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            timer0_count    <= 16'h0000;
            timer1_count    <= 16'h0000;
            timer0_overflow <= 1'b0;
            timer1_overflow <= 1'b0;
        end
        else
        begin
            timer0_count    <= {next_th0, next_tl0};
            timer1_count    <= {next_th1, next_tl1};
            timer0_overflow <= next_ovf0;
            timer1_overflow <= next_ovf1;
        end
    end

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    wire no_ld1 = ~timer1_load.lo_we & ~timer1_load.hi_we;
    wire no_ld0 = ~timer0_load.lo_we & ~timer0_load.hi_we;

    a_t1_free_run: assert property ( // [R1]
        (timer1_ctl.run && !timer1_gate_ctl && mode1 == tmc_pkg::TMC_MODE_16BIT && timer1_ctl.clk_select && !csel1 && no_ld1)
        |=> timer1_count == $past(timer1_count) + 16'd1)
        else $error("timer 1 did not advance with gate clear");

    a_t1_gate_hold: assert property ( // [R2]
        (timer1_gate_ctl && !irq1_active && no_ld1) |=> $stable(timer1_count))
        else $error("timer 1 advanced with gate pin inactive");

    a_t1_edge_only: assert property ( // [R4]
        (csel1 && !in_fall[`TMC_IN_T1] && no_ld1) |=> $stable(timer1_count))
        else $error("timer 1 counted without a falling edge");

    a_t1_stop_mode: assert property ( // [R5]
        (mode1 == tmc_pkg::TMC_MODE_ALT && no_ld1) |=> $stable(timer1_count))
        else $error("timer 1 moved while stopped");

    a_t0_gate_hold: assert property ( // [R6]
        (timer0_gate_ctl && !irq0_active && no_ld0 && !split0) |=> $stable(timer0_count))
        else $error("timer 0 advanced with gate pin inactive");

    a_t0_internal_tick: assert property ( // [R7]
        (run0 && !csel0 && timer0_ctl.clk_select && mode0 == tmc_pkg::TMC_MODE_16BIT && no_ld0)
        |=> timer0_count == $past(timer0_count) + 16'd1)
        else $error("timer 0 missed an internal tick");

    a_t1_reload_low: assert property ( // [R11]
        (en1 && mode1 == tmc_pkg::TMC_MODE_8RELOAD && timer1_count[7:0] == 8'hff && no_ld1)
        |=> timer1_count[7:0] == $past(timer1_count[15:8]) && timer1_overflow)
        else $error("timer 1 reload or overflow missing");

    a_t0_13bit_carry: assert property ( // [R8]
        (en0 && mode0 == tmc_pkg::TMC_MODE_13BIT && timer0_count[4:0] == 5'h1f && no_ld0)
        |=> timer0_count[4:0] == 5'h00 && timer0_count[15:8] == $past(timer0_count[15:8]) + 8'd1)
        else $error("timer 0 13-bit carry wrong");

    a_reg_readback: assert property ( // [R9]
        (sfr_req.wr && mode_hit) ##1 (sfr_req.rd && mode_hit && !sfr_req.wr)
        |=> sfr_rdata == $past(sfr_req.wdata, 2))
        else $error("mode register readback mismatch");

    // a pin fall reaches the edge detector after the synchroniser delay, and for one cycle only
    a_edge_once: assert property ( // [R12]
        $fell(timer0_count_input) |-> ##SYNC_STAGES in_fall[`TMC_IN_T0] ##1 !in_fall[`TMC_IN_T0])
        else $error("count pin edge not seen exactly once");

    c_reload_overflow: cover property (en1 && mode1 == tmc_pkg::TMC_MODE_8RELOAD && st1.ovf);
    c_gate_resume: cover property (timer0_gate_ctl && !irq0_active ##1 irq0_active && en0);
    c_split_upper: cover property (en0h && th0_inc[8]);
    c_edge_count: cover property (csel1 && en1);
endmodule
`default_nettype wire

// *** hw/tmc_params.svh ***
// constants for the dual timer mode control block
`ifndef TMC_PARAMS_SVH
`define TMC_PARAMS_SVH

`define TMC_MODE_ADDR    8'h89
`define TMC_MODE_RESET   8'h00
`define TMC_T1_GATE_BIT  7
`define TMC_T1_CSEL_BIT  6
`define TMC_T1_MODE_LSB  4
`define TMC_T0_GATE_BIT  3
`define TMC_T0_CSEL_BIT  2
`define TMC_T0_MODE_LSB  0
`define TMC_M13_LOW_TOP  5'h1f
`define TMC_BYTE_TOP     8'hff
`define TMC_PSC_DIV12    2'b00
`define TMC_PSC_DIV4     2'b01
`define TMC_PSC_DIV48    2'b10
`define TMC_PSC_EXT8     2'b11
`define TMC_DIV48_LAST   6'd47
`define TMC_DIV12        6'd12
`define TMC_DIV12_LAST   6'd11
`define TMC_DIV4_LAST    2'b11
`define TMC_EXT8_LAST    3'd7
`define TMC_IN_T0        0
`define TMC_IN_T1        1
`define TMC_IN_IRQ0      2
`define TMC_IN_IRQ1      3
`define TMC_IN_XOSC      4
`define TMC_IN_COUNT     5

`endif

// *** hw/tmc_pkg.sv ***
// types shared by the dual timer mode control block
`default_nettype none
package tmc_pkg;
    typedef enum logic [1:0] {TMC_MODE_13BIT, TMC_MODE_16BIT, TMC_MODE_8RELOAD, TMC_MODE_ALT} tmc_mode_t;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tmc_sfr_req_t;
    typedef struct packed {
        logic run;
        logic irq_polarity;
        logic clk_select;
    } tmc_tmr_ctl_t;
    typedef struct packed {
        logic       lo_we;
        logic       hi_we;
        logic [7:0] data;
    } tmc_load_t;
    typedef struct packed {
        logic       ovf;
        logic [7:0] hi;
        logic [7:0] lo;
    } tmc_step_t;
endpackage
`default_nettype wire

// *** hw/tmc_timebase.sv ***
// input synchronisers, falling-edge detect and shared prescaler
`include "tmc_params.svh"
`default_nettype none
module tmc_timebase #(
    parameter int SYNC_STAGES = 2,
    parameter int N_IN        = `TMC_IN_COUNT
) (
    input  wire logic            clk_sys,
    input  wire logic            rst_n,
    input  wire logic [N_IN-1:0] async_in,
    input  wire logic [1:0]      prescale_select,
    output logic      [N_IN-1:0] in_level,
    output logic      [N_IN-1:0] in_fall,
    output logic                 presc_tick
);
    logic [5:0] div_cnt;
    logic [2:0] ext_cnt;
    logic [N_IN-1:0] prev;

    if (SYNC_STAGES < 2) $error("tmc_timebase: SYNC_STAGES must be at least 2");
    if (N_IN != `TMC_IN_COUNT) $error("tmc_timebase: N_IN must match the input map");

    // per input: a plain chain, the last stage feeds the edge detector and the level output
    for (genvar i = 0; i < N_IN; i++)
    begin : g_sync
        logic [SYNC_STAGES-1:0] chain;
        always_ff @(posedge clk_sys)
        begin
            if (!rst_n)
                chain <= '0;
            else
                chain <= {chain[SYNC_STAGES-2:0], async_in[i]};
        end
        assign in_level[i] = chain[SYNC_STAGES-1];
    end

    // one extra sample so each high-to-low step is seen exactly once [R12]
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            prev <= '0;
        else
            prev <= in_level;
    end
    assign in_fall = prev & ~in_level; // [R12]

    // one divider serves /4, /12 and /48 since 48 is a multiple of both
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            div_cnt <= '0;
        else
            div_cnt <= (div_cnt == `TMC_DIV48_LAST) ? 6'd0 : div_cnt + 6'd1;
    end

    // external oscillator divided by eight, counted on its sampled edges
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            ext_cnt <= '0;
        else if (in_fall[`TMC_IN_XOSC])
            ext_cnt <= ext_cnt + 3'd1;
    end

    wire tick4  = (div_cnt[1:0] == `TMC_DIV4_LAST);
    wire tick12 = ((div_cnt % `TMC_DIV12) == `TMC_DIV12_LAST);
    wire tick48 = (div_cnt == `TMC_DIV48_LAST);
    wire tick8x = in_fall[`TMC_IN_XOSC] && (ext_cnt == `TMC_EXT8_LAST);

    // prescaled source choice [R10]
    always_comb
    begin
        unique case (prescale_select)
            `TMC_PSC_DIV12: presc_tick = tick12;
            `TMC_PSC_DIV4:  presc_tick = tick4;
            `TMC_PSC_DIV48: presc_tick = tick48;
            `TMC_PSC_EXT8:  presc_tick = tick8x;
        endcase
    end
endmodule
`default_nettype wire

// *** sim/test_dual_timer_mode_control.sv ***
// self-checking bench for the dual timer mode control block
`default_nettype none
module test_dual_timer_mode_control;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct {
        int          tmr;
        logic [7:0]  mode;
        logic        csel;
        logic [1:0]  presc;
        logic [1:0]  gate;   // polarity, pin level
        logic [15:0] load;
        int          n;
        logic [15:0] want;
        int          ovf;
    } tmc_row_t;

    logic                        clk_sys;
    logic                        rst_n;
    tmc_pkg::tmc_sfr_req_t       sfr_req;
    wire logic [7:0]             sfr_rdata;
    wire logic [7:0]             timer_mode_reg;
    tmc_pkg::tmc_tmr_ctl_t [1:0] tctl;
    logic [1:0]                  prescale_select;
    tmc_pkg::tmc_load_t [1:0]    tload;
    logic [1:0]                  gate_level;
    logic [7:0]                  rd_seen;
    wire logic                   irq0, irq1, cnt0, cnt1, osc;
    wire logic [1:0][15:0]       tcount;
    wire logic [1:0]             tovf;
    int                          ovf_seen [2];
    int                          mismatches, checks, cycles, base;
    tmc_row_t                    r;

    // modes, gating and timebases for both timers; one row per case
    tmc_row_t rows [18] = '{
        '{1, 8'h10, 1'b1, 2'h0, 2'h2, 16'hfffe, 3, 16'h0001, 1},
        '{1, 8'h00, 1'b1, 2'h0, 2'h0, 16'h00ff, 1, 16'h01e0, 0},
        '{1, 8'h20, 1'b1, 2'h0, 2'h0, 16'hf0fe, 3, 16'hf0f1, 1},
        '{1, 8'h30, 1'b1, 2'h0, 2'h0, 16'h0005, 10, 16'h0005, 0},
        '{1, 8'h90, 1'b1, 2'h0, 2'h2, 16'h0000, 10, 16'h0000, 0},
        '{1, 8'h90, 1'b1, 2'h0, 2'h3, 16'h0000, 10, 16'h000a, 0},
        '{1, 8'h90, 1'b1, 2'h0, 2'h0, 16'h0000, 10, 16'h000a, 0},
        '{1, 8'h10, 1'b0, 2'h1, 2'h0, 16'h0000, 40, 16'h000a, 0},
        '{1, 8'h10, 1'b0, 2'h0, 2'h0, 16'h0000, 48, 16'h0004, 0},
        '{1, 8'h10, 1'b0, 2'h2, 2'h0, 16'h0000, 96, 16'h0002, 0},
        '{1, 8'h10, 1'b0, 2'h3, 2'h0, 16'h0000, 96, 16'h0002, 0},
        '{0, 8'h01, 1'b1, 2'h0, 2'h2, 16'hfffe, 3, 16'h0001, 1},
        '{0, 8'h00, 1'b1, 2'h0, 2'h0, 16'h00ff, 1, 16'h01e0, 0},
        '{0, 8'h02, 1'b1, 2'h0, 2'h0, 16'hf0fe, 3, 16'hf0f1, 1},
        '{0, 8'h03, 1'b1, 2'h0, 2'h0, 16'h00fe, 3, 16'h0001, 1},
        '{0, 8'h09, 1'b1, 2'h0, 2'h2, 16'h0000, 10, 16'h0000, 0},
        '{0, 8'h09, 1'b1, 2'h0, 2'h3, 16'h0000, 10, 16'h000a, 0},
        '{0, 8'h01, 1'b0, 2'h1, 2'h0, 16'h0000, 40, 16'h000a, 0}
    };

    tmc_core dut_u (
        .clk_sys            (clk_sys),
        .rst_n              (rst_n),
        .sfr_req            (sfr_req),
        .sfr_rdata          (sfr_rdata),
        .timer_mode_reg     (timer_mode_reg),
        .timer0_ctl         (tctl[0]),
        .timer1_ctl         (tctl[1]),
        .prescale_select    (prescale_select),
        .timer0_load        (tload[0]),
        .timer1_load        (tload[1]),
        .ext_irq0_pin       (irq0),
        .ext_irq1_pin       (irq1),
        .timer0_count_input (cnt0),
        .timer1_count_input (cnt1),
        .ext_osc_in         (osc),
        .timer0_count       (tcount[0]),
        .timer1_count       (tcount[1]),
        .timer0_overflow    (tovf[0]),
        .timer1_overflow    (tovf[1])
    );

    tmc_pin_model pins_u (
        .clk_sys            (clk_sys),
        .gate_level         (gate_level),
        .ext_irq0_pin       (irq0),
        .ext_irq1_pin       (irq1),
        .timer0_count_input (cnt0),
        .timer1_count_input (cnt1),
        .ext_osc_in         (osc)
    );

    // free-running clock at 100 MHz
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // cycle count for the hang guard and a tally of overflow pulses
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (tovf[0] === 1'b1)
            ovf_seen[0] <= ovf_seen[0] + 1;
        if (tovf[1] === 1'b1)
            ovf_seen[1] <= ovf_seen[1] + 1;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        checks++;
        if (seen !== want)
        begin
            mismatches++;
            $display("BAD t=%0t seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // every bus task starts and ends just after a rising edge; one idle edge follows
    // so the strobe is never released and raised again in the same time step
    task automatic bus(input logic wr, input logic [7:0] addr, input logic [7:0] data);
        sfr_req = '{wr: wr, rd: ~wr, addr: addr, wdata: data};
        @(posedge clk_sys);
        #1;
        sfr_req = '0;
        rd_seen = sfr_rdata;
        @(posedge clk_sys);
        #1;
    endtask

    task automatic load(input int t, input logic [15:0] v);
        tload[t] = '{lo_we: 1'b1, hi_we: 1'b0, data: v[7:0]};
        @(posedge clk_sys);
        #1;
        tload[t] = '{lo_we: 1'b0, hi_we: 1'b1, data: v[15:8]};
        @(posedge clk_sys);
        #1;
        tload[t] = '0;
    endtask

    // a hang ends the run through the same closing report
    initial
    begin
        wait (cycles == 4000);
        mismatches++;
        $display("BAD t=%0t run did not finish", $time);
        test_done();
    end

    initial
    begin
        rst_n = 1'b0;
        sfr_req = '0;
        tctl = '0;
        tload = '0;
        prescale_select = 2'h0;
        gate_level = 2'h0;
        repeat (2) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        foreach (rows[i])
        begin
            r = rows[i];
            bus(1'b1, 8'h89, r.mode);
            prescale_select = r.presc;
            gate_level = {2{r.gate[0]}};
            load(r.tmr, r.load);
            tctl[r.tmr] = '{run: 1'b0, irq_polarity: r.gate[1], clk_select: r.csel};
            // gate pin needs its synchroniser delay before the window opens
            repeat (4) @(posedge clk_sys);
            #1;
            base = ovf_seen[r.tmr];
            tctl[r.tmr].run = 1'b1;
            repeat (r.n) @(posedge clk_sys);
            #1;
            tctl[r.tmr].run = 1'b0;
            repeat (2) @(posedge clk_sys);
            #1;
            check(tcount[r.tmr], r.want);
            check(16'(ovf_seen[r.tmr] - base), 16'(r.ovf));
            $display("row %0d done", i);
        end
        // register placement, back-to-back access and unmapped addresses
        bus(1'b1, 8'h89, 8'h5a);
        bus(1'b0, 8'h89, 8'h00);
        check(rd_seen, 8'h5a);
        bus(1'b1, 8'h88, 8'hff);
        bus(1'b0, 8'h88, 8'h00);
        check(rd_seen, 8'h00);
        bus(1'b0, 8'h89, 8'h00);
        check(rd_seen, 8'h5a);
        // write then read on the very next edge; read data stands for one cycle only
        sfr_req = '{wr: 1'b1, rd: 1'b0, addr: 8'h89, wdata: 8'h33};
        @(posedge clk_sys);
        #1;
        sfr_req = '{wr: 1'b0, rd: 1'b1, addr: 8'h89, wdata: 8'h00};
        @(posedge clk_sys);
        #1;
        sfr_req = '0;
        check(sfr_rdata, 8'h33);
        @(posedge clk_sys);
        #1;
        check(sfr_rdata, 8'h00);
        $display("register test done");
        // mode 0x33: timer 1 parked, timer 0 split; its upper byte runs on timer 1's run bit
        load(0, 16'hfe00);
        tctl[0] = '{run: 1'b0, irq_polarity: 1'b0, clk_select: 1'b1};
        tctl[1] = '{run: 1'b1, irq_polarity: 1'b0, clk_select: 1'b0};
        base = ovf_seen[1];
        repeat (3) @(posedge clk_sys);
        #1;
        tctl[1] = '0;
        repeat (2) @(posedge clk_sys);
        #1;
        check(tcount[0], 16'h0100);
        check(16'(ovf_seen[1] - base), 16'h0001);
        check(tcount[1], 16'h0002);
        $display("split test done");
        // counter mode: internal tick also enabled so a wrong source shows up
        for (int t = 0; t < 2; t++)
        begin
            bus(1'b1, 8'h89, (t == 1) ? 8'h50 : 8'h05);
            load(t, 16'h0000);
            load(1 - t, 16'h0000);
            tctl[t] = '{run: 1'b1, irq_polarity: 1'b1, clk_select: 1'b1};
            pins_u.pulse(t, 5);
            repeat (6) @(posedge clk_sys);
            #1;
            tctl[t] = '0;
            check(tcount[t], 16'h0005);
            check(tcount[1 - t], 16'h0000);
        end
        $display("count pin test done");
        // reset in mid-run returns the mode register to zero
        bus(1'b1, 8'h89, 8'ha5);
        rst_n = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        check(timer_mode_reg, 8'h00);
        check(tcount[1], 16'h0000);
        bus(1'b0, 8'h89, 8'h00);
        check(rd_seen, 8'h00);
        $display("reset test done");
        test_done();
    end
endmodule
`default_nettype wire

// *** sim/tmc_pin_model.sv ***
// far-side model: gate pins, count pins and a free-running external oscillator
`default_nettype none
module tmc_pin_model (
    input  wire logic       clk_sys,
    input  wire logic [1:0] gate_level,
    output logic            ext_irq0_pin,
    output logic            ext_irq1_pin,
    output logic            timer0_count_input,
    output logic            timer1_count_input,
    output logic            ext_osc_in
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [1:0] cnt_pins;

    // gate pins simply follow the level the bench asks for
    assign ext_irq0_pin = gate_level[0];
    assign ext_irq1_pin = gate_level[1];
    assign timer0_count_input = cnt_pins[0];
    assign timer1_count_input = cnt_pins[1];

    // oscillator period of six clocks keeps it below a quarter of the clock rate
    initial
    begin
        cnt_pins = 2'h3;
        ext_osc_in = 1'b0;
        forever #30 ext_osc_in = ~ext_osc_in;
    end

    // count pins idle high; low and high phases of three clocks clear the two-clock minimum
    task automatic pulse(input int which, input int n);
        repeat (n)
        begin
            @(posedge clk_sys);
            #1;
            cnt_pins[which] = 1'b0;
            repeat (3) @(posedge clk_sys);
            #1;
            cnt_pins[which] = 1'b1;
            repeat (2) @(posedge clk_sys);
        end
    endtask
endmodule
`default_nettype wire
